// ---- pkg/tpa_pkg.sv ----
package tpa_pkg;

  // ****************************************
  // Sizes and field positions
  // ****************************************
  localparam int          LOC_W          = 5;
  localparam int          DATA_W         = 8;
  localparam int          BUF_DEPTH      = 32;
  localparam int          CNT_W          = 9;
  localparam int          SLOT_MSB       = 8;
  localparam int          SLOT_LSB       = 4;
  localparam int          BIT_MSB        = 3;
  localparam int          BIT_LSB        = 1;
  localparam int          PHASE_MSB      = 3;
  localparam int          CTRL_CH24_BIT  = 5;
  localparam int          CTRL_TXSEL_BIT = 0;

  // ****************************************
  // Values and timing points
  // ****************************************
  localparam logic [3:0]        WIN_PHASE  = 4'hf;
  localparam logic [3:0]        HALF_PHASE = 4'h7;
  localparam logic [DATA_W-1:0] FILL_BYTE  = 8'hff;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [LOC_W-1:0]  CTRL_ADDR  = 5'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    MODE_UP   = 3'b001,
    MODE_FAST = 3'b010,
    MODE_CTRL = 3'b100
  } tpa_mode_t;

  typedef enum logic [2:0] {
    PS_IDLE = 3'b001,
    PS_WAIT = 3'b010,
    PS_ACK  = 3'b100
  } tpa_pstate_t;

  typedef struct packed {
    logic [LOC_W-1:0] slot;
    logic [LOC_W-1:0] nextSlot;
    logic [3:0]       phase;
    logic             window;
    logic             secHalf;
    logic             serStrobe;
    logic             bitStart;
    logic             midBit;
  } tpa_slot_t;

  typedef struct packed {
    logic              master_mode_select;
    logic              ms1;
    logic              chan32;
    logic              bitClk;
    logic              frame_n;
    logic              sin;
    logic              cs_n;
    logic              ds_n;
    logic              rw;
    logic              top;
    logic [LOC_W-1:0]  addr;
    logic [DATA_W-1:0] data;
  } tpa_pins_t;

  typedef struct packed {
    logic              selB;
    logic [LOC_W-1:0]  loc;
    logic [DATA_W-1:0] data;
  } tpa_pwr_t;

  // Timeslot to buffer location: {valid, location}
  function automatic logic [LOC_W:0] tpa_map(input logic [LOC_W-1:0] slot, input logic ch24);
    if (!ch24) begin
      return {1'b1, slot};
    end
    return {slot[1:0] != 2'b00, slot - {2'b00, slot[4:2]} - 5'h01};
  endfunction : tpa_map

endpackage : tpa_pkg

// ---- logic/tpa_slot_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
module tpa_slot_timer (
  input  wire logic          mclk,
  input  wire logic          arst_n,
  input  wire logic          bitClk,
  input  wire logic          frame_n,
  output var tpa_pkg::tpa_slot_t timing
);
  import tpa_pkg::*;

  logic             clkD_r, clkD_nxt;
  logic             frD_r, frD_nxt;
  logic             pend_r, pend_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic             fall, rise, frFall;

  // Count bit-clock falls; a frame pulse restarts at the next fall
  always_comb begin
    fall     = clkD_r & ~bitClk;
    rise     = ~clkD_r & bitClk;
    frFall   = frD_r & ~frame_n;
    clkD_nxt = bitClk;
    frD_nxt  = frame_n;
    pend_nxt = pend_r;
    cnt_nxt  = cnt_r;
    if (fall) begin
      cnt_nxt  = (pend_r | frFall) ? '0 : cnt_r + 9'h001;
      pend_nxt = 1'b0;
    end else if (frFall) begin
      pend_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      clkD_r <= 1'b0;
      frD_r  <= 1'b1;
      pend_r <= 1'b0;
      cnt_r  <= '0;
    end else begin
      clkD_r <= clkD_nxt;
      frD_r  <= frD_nxt;
      pend_r <= pend_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

  // Slot, phase and strobe decode for the rest of the block
  always_comb begin
    timing.slot      = cnt_r[SLOT_MSB:SLOT_LSB];
    timing.nextSlot  = cnt_r[SLOT_MSB:SLOT_LSB] + 5'h01;
    timing.phase     = cnt_r[PHASE_MSB:0];
    timing.window    = cnt_r[PHASE_MSB:0] == WIN_PHASE;
    timing.secHalf   = timing.window & bitClk;
    timing.serStrobe = rise & timing.window;
    timing.bitStart  = fall & ~cnt_nxt[0];
    timing.midBit    = fall & cnt_nxt[0];
  end

  frame_zero_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fall & (pend_r | frFall) |=> cnt_r == '0) else $error("count not restarted by frame");

  count_step_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fall & ~pend_r & ~frFall |=> cnt_r == $past(cnt_r) + 9'h001) else $error("count did not advance");

endmodule : tpa_slot_timer
`default_nettype wire

// ---- logic/tpa_bridge.sv ----
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Mode select high: processor mode always
// - Mode low: submode high fast, low controller
// - Processor mode: two transmit, one receive buffer
// - Processor mode: control bit 5 picks 24
// - Other modes: count pin high means 32
// - 32 channels: location equals timeslot
// - 24 channels: every fourth slot sends FF, except stream B in controller mode
// - Each stream has its own 32-byte buffer
// - Two serial outputs, one serial input
// - Contention only on same location, same time
// - Serial access in last half-cycle only
// - Serial side wins, parallel side waits
// - Acknowledge withheld until access can finish
// - Fast mode: busy during contention window
// - Window spans whole last bit-clock cycle
// - Early access ending first half: no busy
// - Access started in window: busy until window ends
// - Controller mode drives address and strobes
// - Controller mode never arbitrates
// - Low acknowledge: data valid or latched
// - Processor mode: top address bit picks registers or buffers
// - Controller mode: output B repeats input
// - Channel start: low for four bit cells
module tpa_bridge (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        masterModeSelect,
  input  wire logic        submodeSelect,
  input  wire logic        chan32Select,
  input  wire logic        bitClock4m,
  input  wire logic        framePulse_n,
  input  wire logic        serialInStream,
  output logic             serialOutStreamA,
  output logic             serialOutStreamB,
  input  wire logic        chipSelect_n,
  input  wire logic        dataStrobe_n,
  output logic             dataStrobeOut_n,
  output logic             dataStrobeOe,
  input  wire logic        readWrite,
  output logic             writeEnOut_n,
  output logic             writeEnOe,
  input  wire logic [4:0]  addrIn,
  output logic [4:0]       addrOut,
  output logic             addrOe,
  input  wire logic        addressTopBit,
  output logic             chanStartOut_n,
  output logic             chanStartOe,
  input  wire logic [7:0]  dataIn,
  output logic [7:0]       dataOut,
  output logic             dataOe,
  output logic             ackBusyOut,
  output logic             ackBusyOe,
  output logic [7:0]       controlReg
);
  import tpa_pkg::*;

  // ****************************************
  // Pin synchronisers and slot timing
  // ****************************************
  tpa_pins_t   pinRaw, s1_r, s2_r;
  tpa_slot_t   t;
  tpa_mode_t   mode;
  tpa_pstate_t state_r, state_nxt;
  logic [LOC_W:0]    rxMap, txMap;
  logic              ch24, regSel, hit, contend, req, act2, busy;
  logic [DATA_W-1:0] rxBuf [BUF_DEPTH];
  logic [DATA_W-1:0] txBufA [BUF_DEPTH];
  logic [DATA_W-1:0] txBufB [BUF_DEPTH];
  logic [DATA_W-1:0] dlyBuf [BUF_DEPTH];

  // Every pin is asynchronous to mclk, so all pass two flops
  always_comb begin
    pinRaw = '{masterModeSelect, submodeSelect, chan32Select, bitClock4m, framePulse_n,
               serialInStream, chipSelect_n, dataStrobe_n, readWrite, addressTopBit,
               addrIn, dataIn};
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= '{master_mode_select: 1'b1, frame_n: 1'b1, cs_n: 1'b1, ds_n: 1'b1, rw: 1'b1, default: '0};
      s2_r <= '{master_mode_select: 1'b1, frame_n: 1'b1, cs_n: 1'b1, ds_n: 1'b1, rw: 1'b1, default: '0};
    end else begin
      s1_r <= pinRaw;
      s2_r <= s1_r;
    end
  end

  tpa_slot_timer u_timer (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .bitClk  (s2_r.bitClk),
    .frame_n (s2_r.frame_n),
    .timing  (t)
  );

  function automatic tpa_mode_t decodeMode(input logic master_mode_select, input logic ms1);
    if (master_mode_select) begin
      return MODE_UP;
    end
    return ms1 ? MODE_FAST : MODE_CTRL;
  endfunction : decodeMode

  // ****************************************
  // Mode, channel map and contention detect
  // ****************************************
  // Contention is judged per location so other cells never stall
  always_comb begin
    mode    = decodeMode(s2_r.master_mode_select, s2_r.ms1);
    ch24    = (mode == MODE_UP) ? controlReg[CTRL_CH24_BIT]
                                : ~s2_r.chan32;
    rxMap   = tpa_map(t.slot, ch24);
    txMap   = tpa_map(t.nextSlot, ch24);
    regSel  = (mode == MODE_UP) & s2_r.top;
    hit     = ~regSel & (s2_r.rw ? (rxMap[LOC_W] & rxMap[LOC_W-1:0] == s2_r.addr)
                                 : (txMap[LOC_W] & txMap[LOC_W-1:0] == s2_r.addr));
    contend = t.window & hit;
    req     = (mode == MODE_UP) & ~s2_r.cs_n & ~s2_r.ds_n;
    act2    = (mode == MODE_FAST) & ~s2_r.cs_n & (~s2_r.ds_n | ~s2_r.rw);
  end

  // ****************************************
  // Serial side: shifters and buffer access
  // ****************************************
  logic [DATA_W-1:0] shA_r, shA_nxt, shB_r, shB_nxt, shIn_r, shIn_nxt;
  logic              outA_nxt, outB_nxt;

  // Loads happen at the serial strobe, in the window's second half
  always_comb begin
    shA_nxt  = shA_r;
    shB_nxt  = shB_r;
    shIn_nxt = shIn_r;
    outA_nxt = serialOutStreamA;
    outB_nxt = serialOutStreamB;
    if (t.midBit) begin
      shIn_nxt = {shIn_r[DATA_W-2:0], s2_r.sin};
    end
    if (t.serStrobe) begin
      shA_nxt = txMap[LOC_W] ? txBufA[txMap[LOC_W-1:0]] : FILL_BYTE;
      shB_nxt = (mode == MODE_CTRL) ? dlyBuf[t.nextSlot]
              : (txMap[LOC_W] ? txBufB[txMap[LOC_W-1:0]] : FILL_BYTE);
    end else if (t.bitStart) begin
      outA_nxt = shA_r[DATA_W-1];
      outB_nxt = shB_r[DATA_W-1];
      shA_nxt  = {shA_r[DATA_W-2:0], 1'b1};
      shB_nxt  = {shB_r[DATA_W-2:0], 1'b1};
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      shA_r            <= FILL_BYTE;
      shB_r            <= FILL_BYTE;
      shIn_r           <= '0;
      serialOutStreamA <= 1'b1;
      serialOutStreamB <= 1'b1;
    end else begin
      shA_r            <= shA_nxt;
      shB_r            <= shB_nxt;
      shIn_r           <= shIn_nxt;
      serialOutStreamA <= outA_nxt;
      serialOutStreamB <= outB_nxt;
    end
  end

  // Receive byte and one-frame delay line written at the strobe
  always_ff @(posedge mclk) begin
    if (t.serStrobe) begin
      dlyBuf[t.slot] <= shIn_r;
      if (rxMap[LOC_W]) begin
        rxBuf[rxMap[LOC_W-1:0]] <= shIn_r;
      end
    end
  end

  // ****************************************
  // Parallel side: all three modes
  // ****************************************
  tpa_pwr_t          wLat_r, wLat_nxt;
  logic              act2D_r, startWin_r, startWin_nxt;
  logic              wrEn, wrSelB;
  logic [LOC_W-1:0]  wrLoc;
  logic [DATA_W-1:0] wrData, ctrl_nxt, dOut_nxt;
  logic              dOe_nxt, ackOe_nxt, ackOut_nxt, txSelB;
  logic [4:0]        aOut_nxt;
  logic              cStart_nxt, dStrobe_nxt, wEn_nxt, ctlOe;

  always_comb begin
    state_nxt    = state_r;
    ctrl_nxt     = (mode == MODE_UP) ? controlReg : CTRL_RESET; // mode select low clears it
    wLat_nxt     = wLat_r;
    startWin_nxt = 1'b0;
    wrEn         = 1'b0;
    wrSelB       = 1'b0;
    wrLoc        = s2_r.addr;
    wrData       = s2_r.data;
    dOut_nxt     = dataOut;
    dOe_nxt      = 1'b0;
    ackOut_nxt   = 1'b0;
    aOut_nxt     = addrOut;
    cStart_nxt   = 1'b1;
    dStrobe_nxt  = 1'b1;
    wEn_nxt      = 1'b1;
    ctlOe        = (mode == MODE_CTRL);
    txSelB       = (mode == MODE_UP) ? controlReg[CTRL_TXSEL_BIT] : s2_r.top;
    busy         = 1'b0;
    // Processor handshake: acknowledge only once the cell is free
    case (state_r)
      PS_IDLE, PS_WAIT: begin
        if (req & ~contend) begin
          state_nxt = PS_ACK;
          if (s2_r.rw) begin
            dOut_nxt = regSel ? ((s2_r.addr == CTRL_ADDR) ? controlReg : '0)
                              : rxBuf[s2_r.addr];
          end else if (regSel) begin
            if (s2_r.addr == CTRL_ADDR) begin
              ctrl_nxt = s2_r.data;
            end
          end else begin
            wrEn   = 1'b1;
            wrSelB = txSelB;
          end
        end else begin
          state_nxt = req ? PS_WAIT : PS_IDLE;
        end
      end
      PS_ACK: begin
        if (!req) begin
          state_nxt = PS_IDLE;
        end
      end
      default: state_nxt = PS_IDLE;
    endcase
    if (mode == MODE_UP) begin
      dOe_nxt = (state_nxt == PS_ACK) & s2_r.rw;
    end
    // Fast RAM: busy only for the same cell inside the window
    if (mode == MODE_FAST) begin
      startWin_nxt = act2 & ((~act2D_r & t.window) | startWin_r);
      busy = act2 & contend & (startWin_nxt | t.secHalf);
      dOut_nxt = rxBuf[s2_r.addr];
      dOe_nxt  = act2 & s2_r.rw & ~s2_r.ds_n & ~busy;
      if (act2 & ~s2_r.rw & ~busy) begin
        wLat_nxt = '{txSelB, s2_r.addr, s2_r.data};
      end
      if (act2D_r & ~act2 & ~startWin_r) begin
        wrEn   = 1'b1;
        wrSelB = wLat_r.selB;
        wrLoc  = wLat_r.loc;
        wrData = wLat_r.data;
      end
    end
    // Bus controller: strobes timed off the slot counter, no arbitration
    if (mode == MODE_CTRL && rxMap[LOC_W]) begin
      aOut_nxt    = rxMap[LOC_W-1:0];
      cStart_nxt  = t.phase > HALF_PHASE;
      dStrobe_nxt = t.phase > HALF_PHASE;
      wEn_nxt     = t.phase <= HALF_PHASE;
      ackOut_nxt  = t.phase <= HALF_PHASE;
      dOut_nxt    = rxBuf[rxMap[LOC_W-1:0]];
      dOe_nxt     = t.phase > HALF_PHASE;
      if (t.bitStart && t.phase == HALF_PHASE) begin
        wrEn  = 1'b1;
        wrLoc = rxMap[LOC_W-1:0];
      end
    end else if (mode == MODE_CTRL) begin
      ackOut_nxt = 1'b1;
    end
    ackOe_nxt = (mode == MODE_CTRL) | busy | ((mode == MODE_UP) & (state_nxt == PS_ACK));
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_r         <= PS_IDLE;
      controlReg      <= CTRL_RESET;
      wLat_r          <= '0;
      act2D_r         <= 1'b0;
      startWin_r      <= 1'b0;
      dataOut         <= '0;
      dataOe          <= 1'b0;
      ackBusyOut      <= 1'b0;
      ackBusyOe       <= 1'b0;
      addrOut         <= '0;
      addrOe          <= 1'b0;
      chanStartOut_n  <= 1'b1;
      chanStartOe     <= 1'b0;
      dataStrobeOut_n <= 1'b1;
      dataStrobeOe    <= 1'b0;
      writeEnOut_n    <= 1'b1;
      writeEnOe       <= 1'b0;
    end else begin
      state_r         <= (mode == MODE_UP) ? state_nxt : PS_IDLE;
      controlReg      <= ctrl_nxt;
      wLat_r          <= wLat_nxt;
      act2D_r         <= act2;
      startWin_r      <= startWin_nxt;
      dataOut         <= dOut_nxt;
      dataOe          <= dOe_nxt;
      ackBusyOut      <= ackOut_nxt;
      ackBusyOe       <= ackOe_nxt;
      addrOut         <= aOut_nxt;
      addrOe          <= ctlOe;
      chanStartOut_n  <= cStart_nxt;
      chanStartOe     <= ctlOe;
      dataStrobeOut_n <= dStrobe_nxt;
      dataStrobeOe    <= ctlOe;
      writeEnOut_n    <= wEn_nxt;
      writeEnOe       <= ctlOe;
    end
  end

  // Transmit buffers: one parallel write port each
  always_ff @(posedge mclk) begin
    if (wrEn && !wrSelB) begin
      txBufA[wrLoc] <= wrData;
    end
    if (wrEn && wrSelB) begin
      txBufB[wrLoc] <= wrData;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence contendReq;
    (mode == MODE_UP) & req & contend & (state_r != PS_ACK);
  endsequence

  ack_held_a: assert property (contendReq |=> !ackBusyOe) else $error("ack given during contention");

  ack_data_a: assert property ($rose(ackBusyOe) & (mode == MODE_UP) & s2_r.rw |-> dataOe)
    else $error("ack without read data");

  fill_slot_a: assert property (t.serStrobe & ch24 & (t.nextSlot[1:0] == 2'b00) & (mode != MODE_CTRL)
    |=> shA_r == FILL_BYTE) else $error("fill byte not loaded");

  busy_start_a: assert property ((mode == MODE_FAST) & act2 & contend & startWin_r
    |=> ackBusyOe) else $error("busy missing in window");

  busy_window_a: assert property ((mode == MODE_FAST) & ackBusyOe |-> $past(t.window))
    else $error("busy outside window");

  no_arbit_a: assert property ((mode == MODE_CTRL) [*2] |-> state_r == PS_IDLE)
    else $error("arbitration in controller mode");

  chan_start_a: assert property ((mode == MODE_CTRL) & rxMap[LOC_W] & (t.phase == 4'h0)
    |=> !chanStartOut_n) else $error("channel start missing");

  rx_store_a: assert property (t.serStrobe & ~ch24 |=> rxBuf[$past(t.slot)] == $past(shIn_r))
    else $error("receive byte not stored");

  mode_up_a: assert property (s2_r.master_mode_select |-> mode == MODE_UP) else $error("mode decode wrong");

endmodule : tpa_bridge
`default_nettype wire

// ---- dv/tpa_serial_partner.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Serial far end: bit clock, frame pulse, input stream, output capture
// ****************************************
module tpa_serial_partner (
  output var logic       bitClock4m,
  output var logic       framePulse_n,
  output var logic       serialInStream,
  input  wire logic      serialOutStreamA,
  input  wire logic      serialOutStreamB,
  output var logic       winFlag,
  output var logic [4:0] curSlot
);
  logic [7:0] capA [32];
  logic [7:0] capB [32];
  logic [7:0] shA;
  logic [7:0] shB;
  logic [7:0] inByte;
  logic [3:0] ph;
  int         frames;
  int         fallCnt;

  // Bus runs free; frames follow each other with no gap
  initial begin
    {bitClock4m, framePulse_n, serialInStream, winFlag} = 4'he;
    {shA, shB, curSlot} = '0;
    frames = 0;
    fallCnt = 500;                                 // Early frame pulse
    forever begin
      #122;
      bitClock4m = 1'b0;
      curSlot = fallCnt[8:4];
      ph = fallCnt[3:0];
      winFlag = (ph == 4'hf);                      // Last bit-clock cycle of the slot
      inByte = {3'b101, curSlot};
      if (!ph[0]) begin
        serialInStream = inByte[3'd7 - ph[3:1]];   // MSB first, new bit every second fall
      end else begin
        shA = {shA[6:0], serialOutStreamA};        // Sampled mid bit, well clear of edges
        shB = {shB[6:0], serialOutStreamB};
        if (ph == 4'hf) begin
          capA[curSlot] = shA;
          capB[curSlot] = shB;
          if (curSlot == 5'h1f) frames++;
        end
      end
      #122;
      bitClock4m = 1'b1;
      framePulse_n = (fallCnt != 511);             // Low across the fall that starts a frame
      fallCnt = (fallCnt + 1) % 512;
    end
  end
endmodule : tpa_serial_partner
`default_nettype wire

// ---- dv/tpa_bridge_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module tpa_bridge_bench;
  import tpa_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  logic       mclk, arst_n, bitClk, frame_n, sIn, soA, soB, winFlag, addrOe, chStart_n, abOut, abOe, busy, dOe;
  tpa_pins_t  pins;
  logic [4:0] curSlot, addrOut, ua;
  logic [7:0] dout, ctrl, q;
  logic [7:0] expA [32];
  logic [7:0] expB [32];
  int         errors, totalChecks, cycles, n;

  tpa_serial_partner partner_u (
    .bitClock4m       (bitClk),
    .framePulse_n     (frame_n),
    .serialInStream   (sIn),
    .serialOutStreamA (soA),
    .serialOutStreamB (soB),
    .winFlag          (winFlag),
    .curSlot          (curSlot)
  );

  tpa_bridge dut_u (
    .mclk             (mclk),
    .arst_n           (arst_n),
    .masterModeSelect (pins.master_mode_select),
    .submodeSelect    (pins.ms1),
    .chan32Select     (pins.chan32),
    .bitClock4m       (bitClk),
    .framePulse_n     (frame_n),
    .serialInStream   (sIn),
    .serialOutStreamA (soA),
    .serialOutStreamB (soB),
    .chipSelect_n     (pins.cs_n),
    .dataStrobe_n     (pins.ds_n),
    .dataStrobeOut_n  (),
    .dataStrobeOe     (),
    .readWrite        (pins.rw),
    .writeEnOut_n     (),
    .writeEnOe        (),
    .addrIn           (pins.addr),
    .addrOut          (addrOut),
    .addrOe           (addrOe),
    .addressTopBit    (pins.top),
    .chanStartOut_n   (chStart_n),
    .chanStartOe      (),
    .dataIn           (pins.data),
    .dataOut          (dout),
    .dataOe           (dOe),
    .ackBusyOut       (abOut),
    .ackBusyOe        (abOe),
    .controlReg       (ctrl)
  );

  // ****************************************
  // Clock and hang guard
  // ****************************************
  always #20 mclk = ~mclk;

  // Roughly ten frames of work; the ceiling leaves ample slack
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 80000) begin
      errors++;
      summarize();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  // Processor cycle: strobe held until acknowledge is seen low-driven
  // Outputs are looked at on the falling edge, where they have settled
  task automatic ucyc(input logic rd, input logic t, input logic [4:0] a, input logic [7:0] d);
    n = 0;
    @(posedge mclk);
    {pins.cs_n, pins.ds_n, pins.rw, pins.top, pins.addr, pins.data} <= {2'b00, rd, t, a, d};
    do begin
      @(negedge mclk);
      n++;
    end while (!(abOe === 1'b1 && abOut === 1'b0) && n < 40);
    chk("acknowledge", {7'h0, n < 40}, 8'h01);
    chk("read drive", {7'h0, dOe}, {7'h0, rd});
    q = dout;
    @(posedge mclk);
    {pins.cs_n, pins.ds_n} <= 2'b11;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (abOe === 1'b1 && n < 20);
  endtask : ucyc

  // Fast cycle, started just after a window or at its very start
  task automatic fcyc(input logic rd, input logic t, input logic [4:0] a, input logic [7:0] d, input logic inWin);
    busy = 1'b0;
    n = 0;
    if (inWin) @(posedge winFlag);
    else @(negedge winFlag);
    ua = a + (inWin ? curSlot : 5'h00);
    @(posedge mclk);
    {pins.cs_n, pins.ds_n, pins.rw, pins.top, pins.addr, pins.data} <= {1'b0, !rd, rd, t, ua, d};
    repeat (8) begin
      @(negedge mclk);
      busy |= (abOe === 1'b1);
    end
    while (abOe === 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    repeat (4) @(negedge mclk);
    q = dout;
    @(posedge mclk);
    {pins.cs_n, pins.ds_n, pins.rw} <= 3'b111;
    repeat (6) @(posedge mclk);
  endtask : fcyc

  task automatic waitFrames(input int k);
    int f0;
    f0 = partner_u.frames;
    while (partner_u.frames < f0 + k) @(posedge mclk);
  endtask : waitFrames

  // Both output streams against the buffer images for one frame
  task automatic chkFrames(input logic ch24);
    int m;
    for (int s = 0; s < 32; s++) begin
      m = ch24 ? s - s / 4 - 1 : s;
      if (ch24 && s % 4 == 0) begin
        chk("stream A fill", partner_u.capA[s], FILL_BYTE);
        chk("stream B fill", partner_u.capB[s], FILL_BYTE);
      end else begin
        chk("stream A", partner_u.capA[s], expA[m]);
        chk("stream B", partner_u.capB[s], expB[m]);
      end
    end
  endtask : chkFrames

  task automatic summarize;
    $display("checks %0d, errors %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {mclk, arst_n, errors, totalChecks, cycles} = '0;
    pins = '0;
    {pins.cs_n, pins.ds_n, pins.rw, pins.master_mode_select, pins.chan32} = 5'h1f;
    repeat (3) @(posedge mclk);
    chk("control reset", ctrl, CTRL_RESET);
    arst_n <= 1'b1;
    // Processor mode with submode low, which alone would mean controller mode
    for (int b = 0; b < 2; b++) begin
      ucyc(1'b0, 1'b1, CTRL_ADDR, {7'h0, b[0]});
      for (int i = 0; i < 32; i++) begin
        expA[i] = {3'b010, i[4:0]};
        expB[i] = {3'b011, i[4:0]};
        ucyc(1'b0, 1'b0, i[4:0], b ? expB[i] : expA[i]);
      end
    end
    waitFrames(2);
    chkFrames(1'b0);
    for (int i = 0; i < 32; i++) begin
      ucyc(1'b1, 1'b0, i[4:0], 8'h00);
      chk("receive buffer", q, {3'b101, i[4:0]});
    end
    ucyc(1'b1, 1'b1, 5'h03, 8'h00);
    chk("unused register", q, 8'h00);
    @(posedge mclk);
    pins.ms1 <= 1'b1;
    ucyc(1'b0, 1'b1, CTRL_ADDR, 8'h20);
    ucyc(1'b1, 1'b1, CTRL_ADDR, 8'h00);
    chk("control read", q, 8'h20);
    chk("control port", ctrl, 8'h20);
    waitFrames(2);
    chkFrames(1'b1);
    // Fast RAM mode, 32 channels from the pin
    @(posedge mclk);
    pins.master_mode_select <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("address drive", {7'h0, addrOe}, 8'h00);
    fcyc(1'b0, 1'b0, 5'h05, 8'ha5, 1'b0);
    expA[5] = 8'ha5;
    fcyc(1'b0, 1'b1, 5'h06, 8'h5b, 1'b0);
    expB[6] = 8'h5b;
    chk("busy outside window", {7'h0, busy}, 8'h00);
    waitFrames(2);
    chkFrames(1'b0);
    fcyc(1'b1, 1'b0, 5'h00, 8'h00, 1'b1);
    chk("busy same cell", {7'h0, busy}, 8'h01);
    chk("read after serial", q, {3'b101, ua});
    fcyc(1'b1, 1'b0, 5'h08, 8'h00, 1'b1);
    chk("busy other cell", {7'h0, busy}, 8'h00);
    @(posedge mclk);
    pins.chan32 <= 1'b0;
    waitFrames(2);
    chkFrames(1'b1);
    // Bus controller mode
    @(posedge mclk);
    {pins.ms1, pins.chan32} <= 2'b01;
    waitFrames(2);
    chk("address drive", {7'h0, addrOe}, 8'h01);
    for (int i = 0; i < 32; i++) begin
      chk("stream B echo", partner_u.capB[i], {3'b101, i[4:0]});
    end
    n = 0;
    while (chStart_n !== 1'b0 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    n = 0;
    while (chStart_n === 1'b0 && n < 100) begin
      @(posedge mclk);
      n++;
      if (n == 20) chk("bus address", {3'h0, addrOut}, {3'h0, curSlot});
    end
    chk("start pulse width", {7'h0, n >= 47 && n <= 50}, 8'h01);
    summarize();
  end
endmodule : tpa_bridge_bench
`default_nettype wire
